/* design/cae_arith_exec.v */
// Operand addressing and arithmetic/logic execution unit of the 8-bit core
`include "cae_consts.vh"

// Behaviour
// - Direct form uses 8-bit address field, RAM/SPECIAL_FUNCTION_REG
// - Indirect via pointer reg 0/1 or data pointer
// - Register form picks one of eight bank registers
// - Code read at data pointer plus accumulator
// - Bit form picks one of 256 bits
// - Add: register 1 cycle, others 2
// - Add with carry adds carry, same timing
// - Subtract with borrow: register 1, others 2
// - Inc/dec 1/2/3 cycles; pointer increment 1
// - Multiply acc by aux register, 2 cycles
// - Divide acc by aux register, 6 cycles
// - Logic ops act per bit position
// - AND 1/2 cycles to acc, 3 to direct
// - OR same forms and timing as AND
// - XOR 1/2 cycles to acc, 3 to direct
// - Clear, invert, rotates: acc, 1 cycle
// - Nibble exchange on acc, 1 cycle
module cae_arith_exec (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire start_i,
  input wire [4:0] op_i,
  input wire [2:0] form_i,
  input wire [7:0] arg1_i,
  input wire [7:0] arg2_i,
  input wire [2:0] reg_sel_i,
  input wire [1:0] bank_i,
  input wire load_i,
  input wire [2:0] load_sel_i,
  input wire [7:0] load_data_i,
  input wire [7:0] ram_rdata_i,
  input wire [7:0] ext_rdata_i,
  output wire busy_o,
  output wire done_o,
  output wire [7:0] ram_addr_o,
  output wire ram_we_o,
  output wire [7:0] ram_wdata_o,
  output wire [15:0] ext_addr_o,
  output wire ext_re_o,
  output wire [7:0] acc_o,
  output wire [7:0] b_o,
  output wire [15:0] data_pointer_reg_o,
  output wire cy_o,
  output wire ac_o,
  output wire ov_o
);

  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;
  ////////////////////////////////////////////////////////////////////////////
  // Helper functions
  // Cycle count of one operation in one operand form
  function [2:0] cyc_count;
    input [4:0] op;
    input [2:0] form;
    begin
      case (op)
        `CAE_OP_ADD, `CAE_OP_SUM_WITH_CARRY, `CAE_OP_DIFF_WITH_BORROW,
        `CAE_OP_BITWISE_AND, `CAE_OP_BITWISE_OR, `CAE_OP_BITWISE_XOR: begin
          if (form == `CAE_FORM_REG)
            cyc_count = `CAE_CYC_ONE;
          else if (form == `CAE_FORM_DIR_ACC || form == `CAE_FORM_DIR_IMM)
            cyc_count = `CAE_CYC_THREE;
          else
            cyc_count = `CAE_CYC_TWO;
        end
        `CAE_OP_INC, `CAE_OP_MINUS_ONE: begin
          if (form == `CAE_FORM_ACC)
            cyc_count = `CAE_CYC_ONE;
          else if (form == `CAE_FORM_REG)
            cyc_count = `CAE_CYC_TWO;
          else
            cyc_count = `CAE_CYC_THREE;
        end
        `CAE_OP_PRODUCT: cyc_count = `CAE_CYC_TWO;
        `CAE_OP_DIV: cyc_count = `CAE_CYC_DIV;
        `CAE_OP_CODE_READ: cyc_count = `CAE_CYC_CODE_READ;
        `CAE_OP_BIT_TO_CARRY: cyc_count = `CAE_CYC_TWO;
        default: cyc_count = `CAE_CYC_ONE;
      endcase
    end
  endfunction
  // Add or subtract with carry in; returns {cy, ac, ov, result}
  function [10:0] add_sub;
    input [7:0] a;
    input [7:0] b;
    input cin;
    input sub;
    reg [8:0] full;
    reg [4:0] low;
    begin
      if (sub) begin
        full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        add_sub = {full[8], low[4],
                   (a[7] != b[7]) && (full[7] != a[7]), full[7:0]};
      end else begin
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        add_sub = {full[8], low[4],
                   (a[7] == b[7]) && (full[7] != a[7]), full[7:0]};
      end
    end
  endfunction
  // Byte holding a bit of the 256-bit space; low half maps into RAM
  function [7:0] bit_byte;
    input [7:0] bit_addr;
    begin
      if (bit_addr[7])
        bit_byte = {bit_addr[7:3], 3'h0};
      else
        bit_byte = `CAE_BIT_RAM_BASE + {4'h0, bit_addr[6:3]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg [1:0] state_ff;
  reg [2:0] step_ff;
  reg [4:0] op_ff;
  reg [2:0] form_ff;
  reg [7:0] arg1_ff;
  reg [7:0] arg2_ff;
  reg [2:0] reg_sel_ff;
  reg [1:0] bank_ff;
  reg [7:0] ptr_ff;
  reg [7:0] opnd_ff;
  reg we_ff;
  reg [7:0] wdata_ff;
  reg [7:0] acc_ff;
  reg [7:0] b_ff;
  reg [15:0] data_pointer_reg_ff;
  reg cy_ff;
  reg ac_ff;
  reg ov_ff;

  wire run = state_ff[1];
  wire is_ind = form_ff == `CAE_FORM_IND;
  wire is_idp = form_ff == `CAE_FORM_IND_DATA_POINTER_REG;
  wire [2:0] cnt = cyc_count(op_ff, form_ff);
  wire last = run && (step_ff == cnt - 3'h1);
  wire is_incdec = op_ff == `CAE_OP_INC || op_ff == `CAE_OP_MINUS_ONE;
  wire is_logic = op_ff == `CAE_OP_BITWISE_AND ||
                  op_ff == `CAE_OP_BITWISE_OR || op_ff == `CAE_OP_BITWISE_XOR;
  // Memory target: inc/dec of a byte, or logic into a direct byte
  wire mem_tgt = (is_incdec && form_ff != `CAE_FORM_ACC) ||
                 (is_logic && (form_ff == `CAE_FORM_DIR_ACC ||
                               form_ff == `CAE_FORM_DIR_IMM));
  wire cstep = run && (step_ff == cnt - (mem_tgt ? 3'h2 : 3'h1));
  wire [2:0] fetch_step = (is_ind || is_idp) ? 3'h1 : 3'h0;
  wire fetching = run && step_ff == fetch_step;
  ////////////////////////////////////////////////////////////////////////////
  // Operand addressing
  // Register form needs no address field: bank and index make it
  wire [7:0] reg_addr = {3'h0, bank_ff, reg_sel_ff};
  wire [7:0] ptr_addr = {3'h0, bank_ff, 2'h0, reg_sel_ff[0]};
  // Pointer read first, then the pointed byte for the rest of the run
  assign ram_addr_o =
    (is_ind && step_ff == 3'h0) ? ptr_addr :
    is_ind ? ptr_ff :
    (op_ff == `CAE_OP_BIT_TO_CARRY) ? bit_byte(arg1_ff) :
    (form_ff == `CAE_FORM_REG) ? reg_addr :
    arg1_ff;
  // Wide port: data pointer alone, or plus accumulator for code reads
  assign ext_addr_o = (op_ff == `CAE_OP_CODE_READ) ?
                      data_pointer_reg_ff + {8'h00, acc_ff} : data_pointer_reg_ff;
  assign ext_re_o = run && (op_ff == `CAE_OP_CODE_READ || is_idp);
  // Fetched byte is live on its fetch step, held afterwards
  wire [7:0] mem_val = !fetching ? opnd_ff :
                       is_idp ? ext_rdata_i : ram_rdata_i;
  wire [7:0] src = (form_ff == `CAE_FORM_IMM) ? arg1_ff :
                   (form_ff == `CAE_FORM_ACC) ? acc_ff : mem_val;
  wire [7:0] logic_src = (form_ff == `CAE_FORM_DIR_ACC) ? acc_ff :
                         (form_ff == `CAE_FORM_DIR_IMM) ? arg2_ff : src;
  wire [7:0] logic_dst = mem_tgt ? mem_val : acc_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Datapath results
  wire [10:0] sum = add_sub(acc_ff, src,
    (op_ff == `CAE_OP_ADD) ? 1'b0 : cy_ff,
    op_ff == `CAE_OP_DIFF_WITH_BORROW);
  wire [15:0] prod = acc_ff * b_ff;
  wire div_zero = b_ff == 8'h00;
  wire [7:0] quot = div_zero ? acc_ff : acc_ff / b_ff;
  wire [7:0] rem = div_zero ? b_ff : acc_ff % b_ff;
  wire [7:0] incdec_in = (form_ff == `CAE_FORM_ACC) ? acc_ff : mem_val;
  wire [7:0] incdec = (op_ff == `CAE_OP_INC) ? incdec_in + 8'h01 :
                      incdec_in - 8'h01;
  // Logic ops combine each bit with its partner only
  reg [7:0] logic_res;
  always @* begin
    case (op_ff)
      `CAE_OP_BITWISE_AND: logic_res = logic_dst & logic_src;
      `CAE_OP_BITWISE_OR: logic_res = logic_dst | logic_src;
      default: logic_res = logic_dst ^ logic_src;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  // Start is taken only when idle; a start during a run is dropped
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
      step_ff <= 3'h0;
      op_ff <= 5'h00;
      form_ff <= 3'h0;
      arg1_ff <= `CAE_RST_BYTE;
      arg2_ff <= `CAE_RST_BYTE;
      reg_sel_ff <= 3'h0;
      bank_ff <= 2'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          step_ff <= 3'h0;
          if (start_i) begin
            state_ff <= ST_RUN;
            op_ff <= op_i;
            form_ff <= form_i;
            arg1_ff <= arg1_i;
            arg2_ff <= arg2_i;
            reg_sel_ff <= reg_sel_i;
            bank_ff <= bank_i;
          end
        end
        ST_RUN: begin
          if (last)
            state_ff <= ST_IDLE;
          step_ff <= last ? 3'h0 : step_ff + 3'h1;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
  // Pointer and operand capture, registered write for memory targets
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_ff <= `CAE_RST_BYTE;
      opnd_ff <= `CAE_RST_BYTE;
      we_ff <= 1'b0;
      wdata_ff <= `CAE_RST_BYTE;
    end else begin
      if (run && is_ind && step_ff == 3'h0)
        ptr_ff <= ram_rdata_i;
      if (fetching)
        opnd_ff <= mem_val;
      we_ff <= cstep && mem_tgt;
      if (cstep && mem_tgt)
        wdata_ff <= is_incdec ? incdec : logic_res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator, aux register, data pointer and flags
  // Side load is ignored while a run is in flight to keep results intact
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_ff <= `CAE_RST_BYTE;
      b_ff <= `CAE_RST_BYTE;
      data_pointer_reg_ff <= `CAE_RST_WORD;
      cy_ff <= 1'b0;
      ac_ff <= 1'b0;
      ov_ff <= 1'b0;
    end else if (!run && load_i) begin
      case (load_sel_i)
        `CAE_LD_ACC: acc_ff <= load_data_i;
        `CAE_LD_B: b_ff <= load_data_i;
        `CAE_LD_DPL: data_pointer_reg_ff[7:0] <= load_data_i;
        `CAE_LD_DPH: data_pointer_reg_ff[15:8] <= load_data_i;
        `CAE_LD_FLAGS: begin
          cy_ff <= load_data_i[`CAE_FLAG_CY];
          ac_ff <= load_data_i[`CAE_FLAG_AC];
          ov_ff <= load_data_i[`CAE_FLAG_OV];
        end
        default: acc_ff <= acc_ff;
      endcase
    end else if (last) begin
      case (op_ff)
        `CAE_OP_ADD, `CAE_OP_SUM_WITH_CARRY, `CAE_OP_DIFF_WITH_BORROW: begin
          acc_ff <= sum[7:0];
          cy_ff <= sum[10];
          ac_ff <= sum[9];
          ov_ff <= sum[8];
        end
        `CAE_OP_INC, `CAE_OP_MINUS_ONE:
          if (form_ff == `CAE_FORM_ACC)
            acc_ff <= incdec;
        `CAE_OP_INC_DATA_POINTER_REG: data_pointer_reg_ff <= data_pointer_reg_ff + 16'h0001;
        `CAE_OP_PRODUCT: begin
          acc_ff <= prod[7:0];
          b_ff <= prod[15:8];
          cy_ff <= 1'b0;
          ov_ff <= prod[15:8] != 8'h00;
        end
        `CAE_OP_DIV: begin
          acc_ff <= quot;
          b_ff <= rem;
          cy_ff <= 1'b0;
          ov_ff <= div_zero;
        end
        `CAE_OP_BITWISE_AND, `CAE_OP_BITWISE_OR, `CAE_OP_BITWISE_XOR:
          if (!mem_tgt)
            acc_ff <= logic_res;
        `CAE_OP_ZERO_ACC: acc_ff <= 8'h00;
        `CAE_OP_INVERT_ACC: acc_ff <= ~acc_ff;
        `CAE_OP_ROTATE_LEFT: acc_ff <= {acc_ff[6:0], acc_ff[7]};
        `CAE_OP_ROTATE_RIGHT: acc_ff <= {acc_ff[0], acc_ff[7:1]};
        `CAE_OP_ROTATE_LEFT_THRU_CARRY: begin
          acc_ff <= {acc_ff[6:0], cy_ff};
          cy_ff <= acc_ff[7];
        end
        `CAE_OP_ROTATE_RIGHT_THRU_CARRY: begin
          acc_ff <= {cy_ff, acc_ff[7:1]};
          cy_ff <= acc_ff[0];
        end
        `CAE_OP_NIBBLE_EXCHANGE: acc_ff <= {acc_ff[3:0], acc_ff[7:4]};
        `CAE_OP_CODE_READ: acc_ff <= ext_rdata_i;
        `CAE_OP_BIT_TO_CARRY: cy_ff <= mem_val[arg1_ff[2:0]];
        default: acc_ff <= acc_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign busy_o = run;
  assign done_o = last;
  assign ram_we_o = we_ff;
  assign ram_wdata_o = wdata_ff;
  assign acc_o = acc_ff;
  assign b_o = b_ff;
  assign data_pointer_reg_o = data_pointer_reg_ff;
  assign cy_o = cy_ff;
  assign ac_o = ac_ff;
  assign ov_o = ov_ff;
endmodule // cae_arith_exec

/* design/cae_consts.vh */
// Constants for the arithmetic and logic execution block
`ifndef CAE_CONSTS_VH
`define CAE_CONSTS_VH

// Operation codes presented on op_i
`define CAE_OP_ADD 5'h00
`define CAE_OP_SUM_WITH_CARRY 5'h01
`define CAE_OP_DIFF_WITH_BORROW 5'h02
`define CAE_OP_INC 5'h03
`define CAE_OP_MINUS_ONE 5'h04
`define CAE_OP_INC_DATA_POINTER_REG 5'h05
`define CAE_OP_PRODUCT 5'h06
`define CAE_OP_DIV 5'h07
`define CAE_OP_BITWISE_AND 5'h08
`define CAE_OP_BITWISE_OR 5'h09
`define CAE_OP_BITWISE_XOR 5'h0a
`define CAE_OP_ZERO_ACC 5'h0b
`define CAE_OP_INVERT_ACC 5'h0c
`define CAE_OP_ROTATE_LEFT 5'h0d
`define CAE_OP_ROTATE_LEFT_THRU_CARRY 5'h0e
`define CAE_OP_ROTATE_RIGHT 5'h0f
`define CAE_OP_ROTATE_RIGHT_THRU_CARRY 5'h10
`define CAE_OP_NIBBLE_EXCHANGE 5'h11
`define CAE_OP_CODE_READ 5'h12
`define CAE_OP_BIT_TO_CARRY 5'h13

// Operand forms presented on form_i
`define CAE_FORM_REG 3'h0
`define CAE_FORM_DIR 3'h1
`define CAE_FORM_IND 3'h2
`define CAE_FORM_IMM 3'h3
`define CAE_FORM_ACC 3'h4
`define CAE_FORM_DIR_ACC 3'h5
`define CAE_FORM_DIR_IMM 3'h6
`define CAE_FORM_IND_DATA_POINTER_REG 3'h7

// Load selectors for the side load port
`define CAE_LD_ACC 3'h0
`define CAE_LD_B 3'h1
`define CAE_LD_DPL 3'h2
`define CAE_LD_DPH 3'h3
`define CAE_LD_FLAGS 3'h4

// Flag positions in a status byte
`define CAE_FLAG_CY 7
`define CAE_FLAG_AC 6
`define CAE_FLAG_OV 2

// Cycle counts per operation class
`define CAE_CYC_ONE 3'h1
`define CAE_CYC_TWO 3'h2
`define CAE_CYC_THREE 3'h3
`define CAE_CYC_CODE_READ 3'h5
`define CAE_CYC_DIV 3'h6

// Bit space layout and reset values
`define CAE_BIT_RAM_BASE 8'h20
`define CAE_RST_BYTE 8'h00
`define CAE_RST_WORD 16'h0000

`endif

/* testbench/cae_arith_exec_asserts.sv */
// Checker for the arithmetic and logic execution block
`include "cae_consts.vh"
module cae_arith_exec_asserts (
  input logic sys_clk_i,
  input logic rst_n_i,
  input logic start_i,
  input logic [4:0] op_i,
  input logic [2:0] form_i,
  input logic [7:0] arg1_i,
  input logic busy_o,
  input logic done_o,
  input logic [7:0] ram_addr_o,
  input logic ram_we_o,
  input logic [7:0] acc_o,
  input logic [15:0] data_pointer_reg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Classes of the instruction taken at this edge
  wire tk = start_i && !busy_o;
  wire ar = op_i <= `CAE_OP_DIFF_WITH_BORROW;
  wire lg = op_i >= `CAE_OP_BITWISE_AND && op_i <= `CAE_OP_BITWISE_XOR;
  wire src = form_i inside {`CAE_FORM_DIR, `CAE_FORM_IND, `CAE_FORM_IMM};
  wire dst = form_i == `CAE_FORM_DIR_ACC || form_i == `CAE_FORM_DIR_IMM;
  ////////////////////////////////////////////////////////////////////////
  AST_REG_ONE: assert property (
    tk && (ar || lg) && form_i == `CAE_FORM_REG |=> done_o)
    else $error("register form not done in one cycle");
  AST_MEM_TWO: assert property (
    tk && (ar || lg) && src |=> !done_o ##1 done_o)
    else $error("memory operand form not done in two cycles");
  AST_DIR_THREE: assert property (
    tk && lg && dst |=> !done_o [*2] ##1 (done_o && ram_we_o))
    else $error("direct target not written in cycle three");
  AST_DIR_ADDR: assert property (
    tk && ar && form_i == `CAE_FORM_DIR |=> ram_addr_o == $past(arg1_i))
    else $error("direct operand address differs from field");
  AST_MUL_TWO: assert property (
    tk && op_i == `CAE_OP_PRODUCT |=> !done_o ##1 done_o)
    else $error("multiply not done in two cycles");
  AST_DIV_SIX: assert property (
    tk && op_i == `CAE_OP_DIV |=> !done_o [*5] ##1 done_o)
    else $error("divide not done in six cycles");
  AST_DATA_POINTER_REG_INC: assert property (
    tk && op_i == `CAE_OP_INC_DATA_POINTER_REG |=> done_o ##1
    data_pointer_reg_o == $past(data_pointer_reg_o, 2) + 16'h0001)
    else $error("data pointer increment wrong");
  AST_ZERO: assert property (
    tk && op_i == `CAE_OP_ZERO_ACC |=> done_o ##1 acc_o == 8'h00)
    else $error("accumulator clear wrong");
  AST_SWAP: assert property (
    tk && op_i == `CAE_OP_NIBBLE_EXCHANGE |=> done_o ##1
    acc_o == {$past(acc_o[3:0], 2), $past(acc_o[7:4], 2)})
    else $error("nibble exchange wrong");
  AST_WE_DONE: assert property (
    ram_we_o |-> done_o)
    else $error("memory write outside the last cycle");
  // Main scenarios reached
  cover property (tk && op_i == `CAE_OP_DIV);
  cover property (tk && lg && dst);
  cover property (done_o && ram_we_o);
endmodule // cae_arith_exec_asserts

bind cae_arith_exec cae_arith_exec_asserts i_cae_arith_exec_asserts (.*);

/* testbench/cae_mem_model.sv */
// Behavioural internal RAM and program memory beside the execution block
module cae_mem_model (
  input wire logic clk_i,
  input wire logic [7:0] ram_addr_i,
  input wire logic ram_we_i,
  input wire logic [7:0] ram_wdata_i,
  output logic [7:0] ram_rdata_o,
  input wire logic [15:0] ext_addr_i,
  input wire logic ext_re_i,
  output logic [7:0] ext_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] junk = 8'h00;
  // Known start pattern so the bench can predict every byte
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'ha5;
  // Same-cycle read, write lands at the clock edge
  always @(posedge clk_i) if (ram_we_i) mem[ram_addr_i] <= ram_wdata_i;
  assign ram_rdata_o = mem[ram_addr_i];
  // Undriven read lines toggle so stale data never looks valid
  always @(posedge clk_i) junk <= ~junk;
  assign ext_rdata_o = ext_re_i ?
    ext_addr_i[7:0] ^ ext_addr_i[15:8] ^ 8'h3c : junk;
endmodule // cae_mem_model

/* testbench/tb.sv */
// Self-checking bench for the arithmetic and logic execution block
`include "cae_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] n; logic [7:0] a, b, wd; logic [15:0] d;
    logic c, h, v, we;} cae_note_t;
  logic sys_clk_i = 0, rst_n_i = 0, start_i = 0, load_i = 0;
  logic [4:0] op_i = 0;
  logic [2:0] form_i = 0, reg_sel_i = 0, load_sel_i = 0;
  logic [7:0] arg1_i = 0, arg2_i = 0, load_data_i = 0;
  logic [1:0] bank_i = 0;
  wire busy_o, done_o, ram_we_o, ext_re_o, cy_o, ac_o, ov_o;
  wire [7:0] ram_addr_o, ram_wdata_o, acc_o, b_o, ram_rdata_i, ext_rdata_i;
  wire [15:0] ext_addr_o, data_pointer_reg_o;
  int errors = 0, comparisons = 0;
  logic [15:0] cnt = 0;
  bit pend = 0;
  cae_note_t q[$], cur;
  logic [7:0] sh [256];
  logic [7:0] a, b, o, w;
  logic [15:0] d;
  logic c, h, v;
  cae_arith_exec i_cae_arith_exec (.*);
  cae_mem_model i_cae_mem_model (.clk_i(sys_clk_i), .ram_addr_i(ram_addr_o),
    .ram_we_i(ram_we_o), .ram_wdata_i(ram_wdata_o), .ram_rdata_o(ram_rdata_i),
    .ext_addr_i(ext_addr_o), .ext_re_i(ext_re_o), .ext_rdata_o(ext_rdata_i));
  always #4 sys_clk_i = ~sys_clk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic ld(logic [2:0] s, logic [7:0] x);
    @(posedge sys_clk_i);
    load_i <= 1;
    load_sel_i <= s;
    load_data_i <= x;
    @(posedge sys_clk_i);
    load_i <= 0;
  endtask
  // Loads random state, predicts the run, then issues it
  task automatic exec(logic [4:0] op, logic [2:0] f, logic [7:0] x, y);
    cae_note_t e;
    logic [8:0] s;
    logic [15:0] p;
    logic [7:0] ad, k, m, r;
    logic [2:0] rs;
    logic [1:0] bk;
    logic t, dr;
    int i;
    a = 8'($urandom);
    b = y;
    {c, h, v} = 3'($urandom);
    rs = 3'($urandom);
    bk = 2'($urandom);
    ld(`CAE_LD_ACC, a);
    ld(`CAE_LD_B, b);
    ld(`CAE_LD_FLAGS, {c, h, 3'h0, v, 2'h0});
    dr = f == `CAE_FORM_DIR_ACC || f == `CAE_FORM_DIR_IMM;
    ad = f == `CAE_FORM_REG ? {3'h0, bk, rs} : f == `CAE_FORM_IND ?
      sh[{3'h0, bk, 2'h0, rs[0]}] : x;
    o = f == `CAE_FORM_IMM ? x : f == `CAE_FORM_IND_DATA_POINTER_REG ?
      d[7:0] ^ d[15:8] ^ 8'h3c : sh[ad];
    e.we = 0;
    e.n = (f == `CAE_FORM_REG || op == `CAE_OP_INC_DATA_POINTER_REG ||
      op inside {[`CAE_OP_ZERO_ACC:`CAE_OP_NIBBLE_EXCHANGE]}) ? 1 : 2;
    case (op)
      `CAE_OP_ADD, `CAE_OP_SUM_WITH_CARRY, `CAE_OP_DIFF_WITH_BORROW: begin
        t = op != `CAE_OP_ADD && c;
        if (op == `CAE_OP_DIFF_WITH_BORROW) begin
          s = {1'b0, a} - o - t;
          h = a[3:0] < o[3:0] + 5'(t);
          v = (a[7] ^ o[7]) & (s[7] ^ a[7]);
        end else begin
          s = a + o + t;
          h = a[3:0] + o[3:0] + t > 15;
          v = ~(a[7] ^ o[7]) & (s[7] ^ a[7]);
        end
        c = s[8];
        a = s[7:0];
      end
      `CAE_OP_INC, `CAE_OP_MINUS_ONE: begin
        w = (f == `CAE_FORM_ACC ? a : o) +
          (op == `CAE_OP_INC ? 8'h01 : 8'hff);
        if (f == `CAE_FORM_ACC) a = w;
        else e.we = 1;
        e.n = f == `CAE_FORM_ACC ? 1 : f == `CAE_FORM_REG ? 2 : 3;
      end
      `CAE_OP_INC_DATA_POINTER_REG: d = d + 16'h0001;
      `CAE_OP_PRODUCT: begin
        p = a * b;
        {b, a} = p;
        c = 0;
        v = |p[15:8];
      end
      `CAE_OP_DIV: begin
        c = 0;
        v = b == 0;
        if (b != 0) {b, a} = {a % b, a / b};
        e.n = 6;
      end
      `CAE_OP_BITWISE_AND, `CAE_OP_BITWISE_OR, `CAE_OP_BITWISE_XOR: begin
        k = f == `CAE_FORM_DIR_ACC ? a : f == `CAE_FORM_DIR_IMM ? y : o;
        m = dr ? sh[ad] : a;
        r = op == `CAE_OP_BITWISE_AND ? m & k :
          op == `CAE_OP_BITWISE_OR ? m | k : m ^ k;
        if (dr) {e.we, w, e.n} = {1'b1, r, 3'h3};
        else a = r;
      end
      `CAE_OP_ZERO_ACC: a = 8'h00;
      `CAE_OP_INVERT_ACC: a = ~a;
      `CAE_OP_ROTATE_LEFT: a = {a[6:0], a[7]};
      `CAE_OP_ROTATE_LEFT_THRU_CARRY: {c, a} = {a, c};
      `CAE_OP_ROTATE_RIGHT: a = {a[0], a[7:1]};
      `CAE_OP_ROTATE_RIGHT_THRU_CARRY: {a, c} = {c, a};
      `CAE_OP_NIBBLE_EXCHANGE: a = {a[3:0], a[7:4]};
      `CAE_OP_CODE_READ: begin
        p = d + a;
        a = p[7:0] ^ p[15:8] ^ 8'h3c;
        e.n = 5;
      end
      default: begin
        // Low half of the bit space sits in RAM, high half in byte blocks
        k = x[7] ? {x[7:3], 3'h0} : 8'h20 + {4'h0, x[6:3]};
        c = sh[k][x[2:0]];
      end
    endcase
    if (e.we) sh[ad] = w;
    e.wd = w;
    {e.a, e.b, e.c, e.h, e.v, e.d} = {a, b, c, h, v, d};
    q.push_back(e);
    @(posedge sys_clk_i);
    {start_i, op_i, form_i, arg1_i, arg2_i} <= {1'b1, op, f, x, y};
    {reg_sel_i, bank_i} <= {rs, bk};
    @(posedge sys_clk_i);
    start_i <= 0;
    i = 0;
    do @(negedge sys_clk_i); while (done_o !== 1'b1 && ++i < 20);
    if (done_o !== 1'b1) begin
      errors++;
      summarize();
    end
  endtask
  // Takes the oldest note when a run ends and compares the outcome
  always @(negedge sys_clk_i) begin
    if (pend) begin
      chk("acc", cur.a, acc_o);
      chk("aux", cur.b, b_o);
      chk("data_pointer_reg", cur.d, data_pointer_reg_o);
      chk("cy", cur.c, cy_o);
      chk("ac", cur.h, ac_o);
      chk("ov", cur.v, ov_o);
      pend = 0;
    end
    if (busy_o === 1'b1) cnt++;
    if (done_o === 1'b1) begin
      cur = q.pop_front();
      chk("cycles", cur.n, cnt);
      chk("ram_we", cur.we, ram_we_o);
      if (cur.we) chk("ram_wdata", cur.wd, ram_wdata_o);
      cnt = 0;
      pend = 1;
    end
  end
  // Reset, then every operation and operand form in turn
  initial begin
    void'($urandom(20));
    for (int i = 0; i < 256; i++) sh[i] = i[7:0] ^ 8'ha5;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1;
    d = 16'($urandom);
    ld(`CAE_LD_DPL, d[7:0]);
    ld(`CAE_LD_DPH, d[15:8]);
    repeat (3) begin
      for (int k = 0; k < 3; k++)
        for (int f = 0; f < 4; f++)
          exec(5'(k), 3'(f), 8'($urandom) & 8'h7f, 8'($urandom));
      exec(`CAE_OP_ADD, `CAE_FORM_IND_DATA_POINTER_REG, 8'h00, 8'h00);
      for (int k = 8; k < 11; k++)
        for (int f = 0; f < 7; f++)
          if (f != 4) exec(5'(k), 3'(f), 8'($urandom) & 8'h7f,
            8'($urandom));
      for (int k = 3; k < 5; k++)
        for (int f = 0; f < 5; f++)
          if (f != 3) exec(5'(k), 3'(f), 8'($urandom) & 8'h7f,
            8'h00);
      exec(`CAE_OP_INC_DATA_POINTER_REG, `CAE_FORM_ACC, 8'h00, 8'h00);
      exec(`CAE_OP_PRODUCT, `CAE_FORM_ACC, 8'h00, 8'($urandom));
      exec(`CAE_OP_DIV, `CAE_FORM_ACC, 8'h00, 8'($urandom) | 8'h01);
      exec(`CAE_OP_DIV, `CAE_FORM_ACC, 8'h00, 8'h00);
      for (int k = 11; k < 18; k++)
        exec(5'(k), `CAE_FORM_ACC, 8'h00, 8'h00);
      exec(`CAE_OP_CODE_READ, `CAE_FORM_ACC, 8'h00, 8'h00);
      exec(`CAE_OP_BIT_TO_CARRY, `CAE_FORM_DIR, 8'($urandom) & 8'h7f,
        8'h00);
      exec(`CAE_OP_BIT_TO_CARRY, `CAE_FORM_DIR, 8'($urandom) | 8'h80,
        8'h00);
    end
    repeat (2) @(negedge sys_clk_i);
    summarize();
  end
endmodule // tb
